// ===== rtl/sacs_pkg.sv
// shared constants and types for the serial converter control link
// assumes: both ends on one 200 MHz sys_clk, link pins joined by sacs_link_if
package sacs_pkg;

  // ---------------------------------------------------------------
  // frame layout
  // ---------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam int FRAME_EDGES = 8;
  localparam int SAMPLE_START_EDGE = 4;
  localparam logic [3:0] SELF_TEST_CHANNEL = 4'hb;
  localparam logic [7:0] SELF_TEST_CODE = 8'h80;
  localparam logic [7:0] RESULT_RESET = 8'h00;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CONV_CYCLES = 36;
  localparam int SYS_CLK_PERIOD_NS = 5;
  localparam int SHIFT_PERIOD_NS = 80;
  localparam int SHIFT_HALF_CYCLES = SHIFT_PERIOD_NS / 2 / SYS_CLK_PERIOD_NS;
  localparam int CONV_WAIT_EDGES = CONV_CYCLES + 4;
  localparam int FIFO_DEPTH = 8;

  typedef enum logic [1:0] {SACS_IDLE, SACS_SELECT, SACS_SHIFT, SACS_WAIT} sacs_host_state_t;

endpackage : sacs_pkg

// ===== rtl/sacs_link_if.sv
// link pins between the host end and the converter end
// assumes: the bench resolves the data pin from data_oe
`timescale 1ns/1ps
interface sacs_link_if;
  logic cs_n;
  logic shift_clk;
  logic addr_in;
  logic data_out;
  logic data_oe;

  modport device (
    input cs_n,
    input shift_clk,
    input addr_in,
    output data_out,
    output data_oe
  );

  modport host (
    output cs_n,
    output shift_clk,
    output addr_in,
    input data_out,
    input data_oe
  );
endinterface : sacs_link_if

// ===== rtl/sacs_fifo.sv
// small flop fifo with valid/ready on both sides
// assumes: single clock, one write and one read per cycle at most
`timescale 1ns/1ps
module sacs_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;

  assign in_ready = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_ptr];

  always_ff @(posedge sys_clk)
  begin
    if (push)
    begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop)
      begin
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : sacs_fifo

// ===== rtl/sacs_device.sv
// converter end: chip select filter, frame shifter, sample/hold and conversion timer
// assumes: link pins arrive asynchronously; analog result comes in on sample_code
`timescale 1ns/1ps

// What this block does
// RL1 - chip select high: output off, inputs ignored
// RL2 - select recognised after two rises, one fall
// RL3 - result msb appears without shift edge
// RL4 - address captured msb first, rising edges one-four
// RL5 - falls one-four shift result bits two-five
// RL6 - sampling starts after fourth falling edge
// RL7 - falls five-seven shift bits six-eight
// RL8 - eighth fall holds; convert 36 cycles
// RL9 - host waits 36 cycles after eighth edge; host here waits CONV_WAIT_EDGES, 40 cycles
// RL10 - spurious shift edge misaligns frame count
// RL11 - recognised select fall aborts conversion
// RL12 - new frame aborts; keep earlier result
// RL13 - common clock: two cycles recognise select
// RL14 - common clock: raise select after ten; host here raises cs_n two cycles after the eighth fall
// RL15 - strobed hold at delayed eighth fall
// RL16 - clocks independent, no ratio required
// RL17 - channel 1011 converts self-test voltage
// RL18 - finished conversion loads output register
module sacs_device (
  input wire logic sys_clk,
  input wire logic rst,
  sacs_link_if.device link,
  input wire logic [7:0] sample_code,
  output logic [3:0] channel,
  output logic sampling,
  output logic converting,
  output logic result_valid,
  output logic [7:0] result
);
  // ---------------------------------------------------------------
  // synchronisers: link pins are foreign to sys_clk
  // ---------------------------------------------------------------
  logic [1:0] cs_sync;
  logic [1:0] clk_sync;
  logic [1:0] addr_sync;
  logic clk_prev;
  logic shift_rise;
  logic shift_fall;

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      cs_sync <= 2'h3;
      clk_sync <= 2'h0;
      addr_sync <= 2'h0;
      clk_prev <= 1'b0;
    end
    else
    begin
      cs_sync <= {cs_sync[0], link.cs_n};
      clk_sync <= {clk_sync[0], link.shift_clk};
      addr_sync <= {addr_sync[0], link.addr_in};
      clk_prev <= clk_sync[1];
    end
  end

  // ---------------------------------------------------------------
  // chip select filter: two rising then one falling sys_clk edge
  // ---------------------------------------------------------------
  logic [1:0] cs_rise_cnt;
  logic cs_neg_seen;
  logic selected;
  logic select_start;

  // posedge stage: counts two rising edges while select is low; the negedge stage below then completes recognition
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      cs_rise_cnt <= 2'h0;
    end
    else if (cs_sync[1])
    begin
      cs_rise_cnt <= 2'h0; // RL1
    end
    else if (cs_rise_cnt != 2'h2)
    begin
      cs_rise_cnt <= cs_rise_cnt + 2'h1; // RL2
    end
  end

  always_ff @(negedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      cs_neg_seen <= 1'b0;
    end
    else
    begin
      cs_neg_seen <= !cs_sync[1] && (cs_rise_cnt == 2'h2); // RL2 RL13
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      selected <= 1'b0;
    end
    else
    begin
      selected <= cs_neg_seen && !cs_sync[1];
    end
  end

  assign select_start = cs_neg_seen && !cs_sync[1] && !selected;
  // shift edges only count while selected; clocks are free-running relative to each other
  assign shift_rise = selected && !cs_sync[1] && clk_sync[1] && !clk_prev; // RL1 RL16
  assign shift_fall = selected && !cs_sync[1] && !clk_sync[1] && clk_prev; // RL1 RL16

  // ---------------------------------------------------------------
  // frame shifter
  // ---------------------------------------------------------------
  logic [2:0] rise_cnt;
  logic [3:0] fall_cnt;
  logic [3:0] addr_shift;
  logic [7:0] out_shift;
  logic [7:0] prev_result;
  logic hold_go;

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      rise_cnt <= 3'h0;
      addr_shift <= 4'h0;
    end
    else if (select_start)
    begin
      rise_cnt <= 3'h0;
    end
    else if (shift_rise)
    begin
      rise_cnt <= rise_cnt + 3'h1; // RL10
      if (rise_cnt < 3'(sacs_pkg::ADDR_W))
      begin
        addr_shift <= {addr_shift[2:0], addr_sync[1]}; // RL4
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      fall_cnt <= 4'h0;
      out_shift <= sacs_pkg::RESULT_RESET;
      channel <= 4'h0;
      sampling <= 1'b0;
    end
    else if (select_start)
    begin
      fall_cnt <= 4'h0;
      sampling <= 1'b0; // RL11
      out_shift <= prev_result; // RL3 RL12
    end
    else if (shift_fall)
    begin
      out_shift <= {out_shift[6:0], 1'b0}; // RL5 RL7
      if (fall_cnt == 4'(sacs_pkg::SAMPLE_START_EDGE - 1))
      begin
        channel <= addr_shift; // RL6
        sampling <= 1'b1; // RL6
      end
      if (fall_cnt == 4'(sacs_pkg::FRAME_EDGES - 1))
      begin
        fall_cnt <= 4'h0; // RL10
        sampling <= 1'b0; // RL8 RL15
        out_shift <= prev_result;
      end
      else
      begin
        fall_cnt <= fall_cnt + 4'h1;
      end
    end
    else if (result_valid)
    begin
      out_shift <= prev_result;
    end
  end

  assign hold_go = shift_fall && (fall_cnt == 4'(sacs_pkg::FRAME_EDGES - 1)); // RL8 RL15

  // ---------------------------------------------------------------
  // conversion timer
  // ---------------------------------------------------------------
  logic [5:0] conv_cnt;
  logic [7:0] held_code;

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      conv_cnt <= 6'h0;
      converting <= 1'b0;
      held_code <= 8'h00;
    end
    else if (select_start)
    begin
      converting <= 1'b0; // RL11
      conv_cnt <= 6'h0;
    end
    else if (hold_go)
    begin
      converting <= 1'b1; // RL8 RL12
      conv_cnt <= 6'h0;
      held_code <= (channel == sacs_pkg::SELF_TEST_CHANNEL) ?
        sacs_pkg::SELF_TEST_CODE : sample_code; // RL17
    end
    else if (converting)
    begin
      if (conv_cnt == 6'(sacs_pkg::CONV_CYCLES - 1))
      begin
        converting <= 1'b0; // RL8
      end
      conv_cnt <= conv_cnt + 6'h1;
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      prev_result <= sacs_pkg::RESULT_RESET;
      result_valid <= 1'b0;
    end
    else
    begin
      result_valid <= 1'b0;
      if (converting && !select_start && !hold_go &&
          conv_cnt == 6'(sacs_pkg::CONV_CYCLES - 1))
      begin
        prev_result <= held_code; // RL18
        result_valid <= 1'b1;
      end
    end
  end

  assign result = prev_result;

  // ---------------------------------------------------------------
  // pin drive: data pin released whenever select is high
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      link.data_oe <= 1'b0;
      link.data_out <= 1'b0;
    end
    else
    begin
      link.data_oe <= selected && !cs_sync[1]; // RL1
      link.data_out <= out_shift[7]; // RL3
    end
  end
endmodule : sacs_device

// ===== rtl/sacs_host.sv
// host end: issues frames from a channel request fifo and returns the previous result
// assumes: shift clock is made here by a divider of sys_clk
`timescale 1ns/1ps
module sacs_host (
  input wire logic sys_clk,
  input wire logic rst,
  sacs_link_if.host link,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic [3:0] req_channel,
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  output logic busy
);
  // ---------------------------------------------------------------
  // request fifo: back-pressure reaches req_ready
  // ---------------------------------------------------------------
  logic fifo_valid;
  logic fifo_ready;
  logic [3:0] fifo_ch;

  sacs_fifo #(.WIDTH(4), .DEPTH(sacs_pkg::FIFO_DEPTH)) u_fifo (
    .sys_clk(sys_clk),
    .rst(rst),
    .in_valid(req_valid),
    .in_ready(req_ready),
    .in_data(req_channel),
    .out_valid(fifo_valid),
    .out_ready(fifo_ready),
    .out_data(fifo_ch)
  );

  // ---------------------------------------------------------------
  // frame sequencer
  // ---------------------------------------------------------------
  logic [1:0] data_sync;
  sacs_pkg::sacs_host_state_t state;
  logic [5:0] tick;
  logic [3:0] edges;
  logic [3:0] ch;
  logic [7:0] rx;
  logic half;

  assign fifo_ready = (state == sacs_pkg::SACS_IDLE);
  assign busy = (state != sacs_pkg::SACS_IDLE);
  assign half = (tick == 6'(sacs_pkg::SHIFT_HALF_CYCLES - 1));

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      data_sync <= 2'h0;
    end
    else
    begin
      data_sync <= {data_sync[0], link.data_out};
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      state <= sacs_pkg::SACS_IDLE;
      tick <= 6'h0;
      edges <= 4'h0;
      ch <= 4'h0;
      rx <= 8'h00;
      link.cs_n <= 1'b1;
      link.shift_clk <= 1'b0;
      link.addr_in <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_data <= 8'h00;
    end
    else
    begin
      rsp_valid <= 1'b0;
      unique case (state)
        sacs_pkg::SACS_IDLE:
        begin
          tick <= 6'h0;
          if (fifo_valid)
          begin
            ch <= fifo_ch;
            link.cs_n <= 1'b0;
            state <= sacs_pkg::SACS_SELECT;
          end
        end
        sacs_pkg::SACS_SELECT:
        begin
          // margin for the device select filter plus synchronisers
          tick <= tick + 6'h1;
          if (tick == 6'h0f)
          begin
            tick <= 6'h0;
            edges <= 4'h0;
            link.addr_in <= ch[3]; // RL4
            ch <= {ch[2:0], 1'b0};
            state <= sacs_pkg::SACS_SHIFT;
          end
        end
        sacs_pkg::SACS_SHIFT:
        begin
          tick <= half ? 6'h0 : tick + 6'h1;
          if (half && !link.shift_clk)
          begin
            link.shift_clk <= 1'b1;
            rx <= {rx[6:0], data_sync[1]};
          end
          else if (half)
          begin
            link.shift_clk <= 1'b0;
            link.addr_in <= ch[3];
            ch <= {ch[2:0], 1'b0};
            edges <= edges + 4'h1;
            // select stays low here: a rise in the same cycle would mask the last fall
            if (edges == 4'(sacs_pkg::FRAME_EDGES - 1))
            begin
              state <= sacs_pkg::SACS_WAIT;
            end
          end
        end
        sacs_pkg::SACS_WAIT:
        begin
          // select stays high through the conversion
          tick <= tick + 6'h1; // RL9 RL11
          if (tick == 6'h01)
          begin
            link.cs_n <= 1'b1; // RL9
          end
          if (tick == 6'(sacs_pkg::CONV_WAIT_EDGES))
          begin
            rsp_valid <= 1'b1;
            rsp_data <= rx;
            state <= sacs_pkg::SACS_IDLE;
          end
        end
      endcase
    end
  end
endmodule : sacs_host

// ===== sim/sacs_asserts.sv
// link checker: wire relations between the host end and the converter end
// assumes: one sys_clk domain; instanced beside the joining link
`timescale 1ns/1ps
module sacs_asserts (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic cs_n,
  input wire logic shift_clk,
  input wire logic addr_in,
  input wire logic data_out,
  input wire logic data_oe
);
  // ----------
  // helpers
  // ----------
  logic [3:0] falls;
  logic [5:0] hi_cnt;
  always_ff @(posedge sys_clk or posedge rst)
    if (rst)
      falls <= 4'h0;
    else if (cs_n)
      falls <= 4'h0;
    else if ($fell(shift_clk))
      falls <= falls + 4'h1;
  // saturates, so the first frame after reset is not held to the gap
  always_ff @(posedge sys_clk or posedge rst)
    if (rst)
      hi_cnt <= 6'h3f;
    else if (!cs_n)
      hi_cnt <= 6'h00;
    else if (hi_cnt != 6'h3f)
      hi_cnt <= hi_cnt + 6'h01;
  // ----------
  // properties
  // ----------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence s_filter; !data_oe [*2]; endsequence
  sequence s_drive; ##[0:5] data_oe; endsequence
  property p_select; $fell(cs_n) |-> s_filter ##1 s_drive; endproperty
  property p_cause; $rose(data_oe) |-> !cs_n && !$past(cs_n, 3); endproperty
  property p_release; cs_n [*5] |-> !data_oe; endproperty
  property p_idle; cs_n |-> !shift_clk; endproperty
  property p_hold; $rose(shift_clk) |-> $stable(data_out) [*7]; endproperty
  property p_addr; $rose(shift_clk) |-> $stable(addr_in) ##1 $stable(addr_in); endproperty
  property p_count; !cs_n |-> falls <= 4'h8; endproperty
  property p_gap; $fell(cs_n) |-> hi_cnt >= 6'h24; endproperty
  a_select: assert property (p_select) else $error("output enable late or early");
  a_cause: assert property (p_cause) else $error("output enable without select");
  a_release: assert property (p_release) else $error("output driven while deselected");
  a_idle: assert property (p_idle) else $error("shift clock high while deselected");
  a_hold: assert property (p_hold) else $error("data moved in high phase");
  a_addr: assert property (p_addr) else $error("address moved at rising edge");
  a_count: assert property (p_count) else $error("more than eight shift pulses");
  a_gap: assert property (p_gap) else $error("conversion gap too short");
endmodule : sacs_asserts

// ===== sim/tb_serial_adc_control_sequencer.sv
// bench: host and converter ends on one link, a bare converter on a second link
// assumes: rtl files compiled first; second link driven here, rules broken on purpose
`timescale 1ns/1ps
module tb_serial_adc_control_sequencer;
  typedef struct {logic [3:0] ch; logic [7:0] code; logic [7:0] exp;} sacs_row_t;
  sacs_row_t rows [5] = '{'{4'h0, 8'h5a, 8'h5a}, '{4'h3, 8'hff, 8'hff},
    '{4'hb, 8'h12, sacs_pkg::SELF_TEST_CODE}, '{4'ha, 8'h00, 8'h00}, '{4'h7, 8'h81, 8'h81}};
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic req_valid = 1'b0;
  logic [3:0] req_channel = 4'h0;
  logic [7:0] sample_code = 8'h00;
  logic [7:0] code2 = 8'h00;
  logic req_ready, rsp_valid, busy, converting2, sampling2;
  logic [7:0] rsp_data, result, result2, prev, got, got_data;
  logic [3:0] channel, channel2, got_addr;
  logic [3:0] n_rise = 4'h0;
  logic result_valid;
  logic sclk_prev = 1'b0;
  logic cs_prev = 1'b1;
  int rv_count = 0;
  int errors = 0;
  int check_count = 0;
  int cycles = 0;
  int n;
  sacs_link_if link();
  sacs_link_if link2();
  sacs_host sacs_host_inst (.sys_clk(sys_clk), .rst(rst), .link(link), .req_valid(req_valid),
    .req_ready(req_ready), .req_channel(req_channel), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .busy(busy));
  sacs_device sacs_device_inst (.sys_clk(sys_clk), .rst(rst), .link(link),
    .sample_code(sample_code), .channel(channel), .sampling(), .converting(),
    .result_valid(result_valid), .result(result));
  sacs_device sacs_device_inst_b (.sys_clk(sys_clk), .rst(rst), .link(link2),
    .sample_code(code2), .channel(channel2), .sampling(sampling2),
    .converting(converting2), .result_valid(), .result(result2));
  sacs_asserts sacs_asserts_inst (.sys_clk(sys_clk), .rst(rst), .cs_n(link.cs_n),
    .shift_clk(link.shift_clk), .addr_in(link.addr_in), .data_out(link.data_out),
    .data_oe(link.data_oe));
  initial forever #2.5 sys_clk = ~sys_clk;
  // ----------
  // tasks
  // ----------
  task automatic cyc(input int k);
    repeat (k) @(negedge sys_clk);
  endtask : cyc
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic end_of_test();
    if (errors == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : end_of_test
  task automatic wait_rsp();
    int w;
    w = 0;
    while (rsp_valid !== 1'b1 && w < 400)
    begin
      cyc(1);
      w++;
    end
    check(8'(rsp_valid), 8'h01);
  endtask : wait_rsp
  // a long hold keeps the eighth pulse high and moves the input mid-pulse
  task automatic frame2(input logic [3:0] ch, input int hold, input int gap);
    link2.cs_n = 1'b0;
    cyc(16);
    for (int i = 0; i < 8; i++)
    begin
      link2.addr_in = (i < 4) ? ch[3 - i] : 1'b0;
      cyc(8);
      link2.shift_clk = 1'b1;
      got = {got[6:0], link2.data_out};
      if (i == 7 && hold > 8)
      begin
        cyc(8);
        check(8'(sampling2), 8'h01);
        code2 = 8'ha5;
      end
      cyc((i == 7 && hold > 8) ? hold - 8 : 8);
      link2.shift_clk = 1'b0;
    end
    cyc(8);
    link2.cs_n = 1'b1;
    cyc(gap);
  endtask : frame2
  // ----------
  // wire monitor and timeout
  // ----------
  always @(posedge sys_clk)
  begin
    sclk_prev <= link.shift_clk;
    cs_prev <= link.cs_n;
    rv_count <= rv_count + ((result_valid === 1'b1) ? 1 : 0);
    if (link.shift_clk && !sclk_prev)
    begin
      // only the first four rises carry the address
      if (n_rise < 4'h4)
      begin
        got_addr <= {got_addr[2:0], link.addr_in};
      end
      got_data <= {got_data[6:0], link.data_out};
    end
    n_rise <= (cs_prev && !link.cs_n) ? 4'h0 : n_rise + 4'(link.shift_clk && !sclk_prev);
    cycles <= cycles + 1;
    if (cycles == 30000)
    begin
      errors++;
      end_of_test();
    end
  end
  // ----------
  // sequence
  // ----------
  initial
  begin
    link2.cs_n = 1'b1;
    link2.shift_clk = 1'b0;
    link2.addr_in = 1'b1;
    cyc(6);
    rst = 1'b0;
    check(8'(link.cs_n), 8'h01);
    check(8'(link.data_oe), 8'h00);
    check(result, sacs_pkg::RESULT_RESET);
    prev = sacs_pkg::RESULT_RESET;
    foreach (rows[r])
    begin
      req_channel = rows[r].ch;
      sample_code = rows[r].code;
      req_valid = 1'b1;
      cyc(1);
      req_valid = 1'b0;
      wait_rsp();
      check(rsp_data, prev);
      check(got_data, prev);
      check(8'(got_addr), 8'(rows[r].ch));
      check(8'(n_rise), 8'h08);
      cyc(10);
      check(result, rows[r].exp);
      check(8'(channel), 8'(rows[r].ch));
      prev = rows[r].exp;
    end
    check(8'(rv_count), 8'h05);
    // fill the request buffer until it refuses, then drain it
    req_channel = 4'h2;
    sample_code = 8'h42;
    req_valid = 1'b1;
    n = 0;
    while (req_ready === 1'b1 && n < 12)
    begin
      n++;
      cyc(1);
    end
    req_valid = 1'b0;
    check(8'(n > 7 && n < 10), 8'h01);
    check(8'(req_ready), 8'h00);
    for (int k = 0; k < n; k++)
    begin
      wait_rsp();
      check(rsp_data, (k == 0) ? prev : 8'h42);
      cyc(1);
    end
    cyc(60);
    check(8'(busy), 8'h00);
    // second link: pulses while deselected must be ignored
    repeat (16)
    begin
      cyc(8);
      link2.shift_clk = ~link2.shift_clk;
    end
    check(8'(link2.data_oe), 8'h00);
    check(8'(channel2), 8'h00);
    code2 = 8'h3c;
    frame2(4'h5, 8, 45);
    check(got, sacs_pkg::RESULT_RESET);
    frame2(4'h9, 40, 45);
    check(got, 8'h3c);
    code2 = 8'h77;
    frame2(4'h5, 8, 6);
    check(got, 8'ha5);
    check(8'(converting2), 8'h01);
    code2 = 8'h11;
    frame2(4'h6, 8, 45);
    check(got, 8'ha5);
    frame2(4'h6, 8, 45);
    check(got, 8'h11);
    check(result2, 8'h11);
    check(8'(converting2), 8'h00);
    check(8'(channel2), 8'h06);
    // second reset in mid-run: results fall back to their reset value
    rst = 1'b1;
    cyc(2);
    rst = 1'b0;
    check(result, sacs_pkg::RESULT_RESET);
    check(result2, sacs_pkg::RESULT_RESET);
    check(8'(link.data_oe), 8'h00);
    end_of_test();
  end
endmodule : tb_serial_adc_control_sequencer
